// >>> hdl/dcf_pkg.sv
// Shared constants, types and pointer helpers for the nine-bit deep FIFO.
// Assumes every user sits in the single clk_in domain.
package dcf_pkg;

  localparam int unsigned DATA_W = 9;
  localparam int unsigned OFS_W  = 8;
  localparam int unsigned CNT_W  = 16;
  localparam int unsigned PIN_W  = 17;

  // Offset register reset values: both thresholds start at seven words
  localparam logic [OFS_W-1:0] OFS_EMPTY_LOW_RST  = 8'h07;
  localparam logic [OFS_W-1:0] OFS_EMPTY_HIGH_RST = 8'h00;
  localparam logic [OFS_W-1:0] OFS_FULL_LOW_RST   = 8'h07;
  localparam logic [OFS_W-1:0] OFS_FULL_HIGH_RST  = 8'h00;

  localparam logic [DATA_W-1:0] READ_DATA_RST  = 9'h000;
  localparam logic              EMPTY_N_RST    = 1'h0;
  localparam logic              AEMPTY_N_RST   = 1'h0;
  localparam logic              FULL_N_RST     = 1'h1;
  localparam logic              AFULL_N_RST    = 1'h1;

  typedef enum logic [1:0] {
    OFS_EMPTY_LOW  = 2'b00,
    OFS_EMPTY_HIGH = 2'b01,
    OFS_FULL_LOW   = 2'b10,
    OFS_FULL_HIGH  = 2'b11
  } dcf_ofs_sel_t;

  typedef enum logic {
    MODE_PROG_FLAGS  = 1'b0,
    MODE_TWO_ENABLES = 1'b1
  } dcf_mode_t;

  function automatic logic [CNT_W-1:0] dcf_bin2gray(input logic [CNT_W-1:0] b);
    return b ^ (b >> 1);
  endfunction

  function automatic logic [CNT_W-1:0] dcf_gray2bin(input logic [CNT_W-1:0] g);
    logic [CNT_W-1:0] b;
    b[CNT_W-1] = g[CNT_W-1];
    for (int i = CNT_W - 2; i >= 0; i--) begin
      b[i] = b[i+1] ^ g[i];
    end
    return b;
  endfunction

endpackage

// >>> hdl/dcf_sync2.sv
// Two-flop level synchroniser, any width.
// Assumes the sampled bits are levels; multi-bit values must be gray coded.
module dcf_sync2
  import dcf_pkg::*;
#(
  parameter int unsigned WIDTH = 1
) (
  // Clock and reset
  input  wire logic             clk_in,
  input  wire logic             sys_rst_in,
  // Levels in and out
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
  } dcf_sync_st_t;

  dcf_sync_st_t st_q;
  dcf_sync_st_t st_d;

  // The first stage feeds only the second stage
  always_comb begin
    st_d.meta   = async_in;
    st_d.stable = st_q.meta;
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign sync_out = st_q.stable;

endmodule

// >>> hdl/dcf_buf2.sv
// Two-entry valid/ready buffer between the array read port and the reader.
// Assumes the source only pushes while in_ready_out is high.
module dcf_buf2
  import dcf_pkg::*;
#(
  parameter int unsigned WIDTH = DATA_W
) (
  // Clock and reset
  input  wire logic             clk_in,
  input  wire logic             sys_rst_in,
  input  wire logic             flush_in,
  // Filling side
  input  wire logic             in_valid_in,
  input  wire logic [WIDTH-1:0] in_data_in,
  output logic                  in_ready_out,
  // Draining side
  output logic                  out_valid_out,
  output logic      [WIDTH-1:0] out_data_out,
  input  wire logic             out_ready_in
);

  typedef struct packed {
    logic [WIDTH-1:0] head;
    logic [WIDTH-1:0] tail;
    logic [1:0]       count;
  } dcf_buf_st_t;

  dcf_buf_st_t st_q;
  dcf_buf_st_t st_d;
  logic        push;
  logic        pop;

  always_comb begin
    st_d = st_q;
    push = in_valid_in && (st_q.count != 2'd2);
    pop  = out_ready_in && (st_q.count != 2'd0);
    if (pop) begin
      st_d.head = st_q.tail;
    end
    if (push) begin
      if ((st_q.count == 2'd0) || (pop && (st_q.count == 2'd1))) begin
        st_d.head = in_data_in;
      end else begin
        st_d.tail = in_data_in;
      end
    end
    st_d.count = st_q.count + {1'b0, push} - {1'b0, pop};
    if (flush_in) begin
      st_d.count = 2'd0;
    end
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign in_ready_out  = st_q.count != 2'd2;
  assign out_valid_out = st_q.count != 2'd0;
  assign out_data_out  = st_q.head;

endmodule

// >>> hdl/dcf_fifo.sv
// Nine-bit deep FIFO with offset-programmable almost-empty/almost-full flags.
// Assumes all pins are asynchronous to clk_in; pin clocks must run well
// below a quarter of clk_in so every pin edge is seen.
// Notes on behaviour
// R01 - Array of 16K or 32K nine-bit words
// R02 - Store word: enable one low, two high, not full
// R03 - Writes fill array in order, independent of reads
// R04 - Read edge with both enables low presents next word
// R05 - Writes ignored while full
// R06 - Reads ignored while empty; last word held
// R07 - Reset empties buffer; flags valid; data low
// R08 - Host resets first; no traffic during reset
// R09 - Output enable high floats data outputs
// R10 - Dual pin sampled at reset selects mode
// R11 - Flag mode: enable one gates writes, load high
// R12 - Four eight-bit offset registers, readable and writable
// R13 - Offset writes cycle through four registers, wrapping
// R14 - Offset position kept across load high periods
// R15 - Offset reads follow same register sequence
// R16 - Host avoids simultaneous offset write and read
// R17 - Thresholds are sixteen-bit high:low byte pairs
// R18 - Almost empty low at n or fewer words
// R19 - Almost full low when free locations reach m
// R20 - Full flag low at capacity, write edges only
// R21 - Empty flag low when empty, read edges only
// R22 - Both offsets default to seven words
// R23 - Pointers cross sides gray coded, two flops
// R24 - Load low, enable one high: nothing happens
module dcf_fifo
  import dcf_pkg::*;
#(
  parameter int unsigned ADDR_W = 14
) (
  // Clock and reset
  input  wire logic              clk_in,
  input  wire logic              sys_rst_in,
  // Device pins, asynchronous to clk_in
  input  wire logic              reset_n_in,
  input  wire logic              write_clk_in,
  input  wire logic [DATA_W-1:0] write_data_in,
  input  wire logic              write_enable_a_n_in,
  input  wire logic              write_enable_b_or_load_in,
  input  wire logic              read_clk_in,
  input  wire logic              read_enable_a_n_in,
  input  wire logic              read_enable_b_n_in,
  input  wire logic              output_enable_n_in,
  // Data output as value and drive enable
  output logic      [DATA_W-1:0] read_data_out,
  output logic                   read_data_oe_out,
  // Status flags, active low
  output logic                   empty_flag_n_out,
  output logic                   full_flag_n_out,
  output logic                   almost_empty_n_out,
  output logic                   almost_full_n_out
);

  localparam logic [CNT_W-1:0] DEPTH = CNT_W'(1 << ADDR_W); // R01

  typedef struct packed {
    dcf_mode_t          mode;
    logic               wclk_prev;
    logic               rclk_prev;
    logic [CNT_W-1:0]   wr_ptr;
    logic [CNT_W-1:0]   wr_gray;
    logic               full_n;
    logic               afull_n;
    logic [CNT_W-1:0]   rd_ptr;
    logic [CNT_W-1:0]   rd_gray;
    logic [CNT_W-1:0]   fetch_ptr;
    logic               fetch_pend;
    logic               empty_n;
    logic               aempty_n;
    logic [DATA_W-1:0]  rdata;
    logic               oe;
    dcf_ofs_sel_t       ofs_sel;
    logic [OFS_W-1:0]   ofs_el;
    logic [OFS_W-1:0]   ofs_eh;
    logic [OFS_W-1:0]   ofs_fl;
    logic [OFS_W-1:0]   ofs_fh;
  } dcf_state_t;

  localparam dcf_state_t ST_RST = '{
    mode:       MODE_PROG_FLAGS,
    wclk_prev:  1'b0,
    rclk_prev:  1'b0,
    wr_ptr:     '0,
    wr_gray:    '0,
    full_n:     FULL_N_RST,
    afull_n:    AFULL_N_RST,
    rd_ptr:     '0,
    rd_gray:    '0,
    fetch_ptr:  '0,
    fetch_pend: 1'b0,
    empty_n:    EMPTY_N_RST,
    aempty_n:   AEMPTY_N_RST,
    rdata:      READ_DATA_RST,
    oe:         1'b0,
    ofs_sel:    OFS_EMPTY_LOW,
    ofs_el:     OFS_EMPTY_LOW_RST,
    ofs_eh:     OFS_EMPTY_HIGH_RST,
    ofs_fl:     OFS_FULL_LOW_RST,
    ofs_fh:     OFS_FULL_HIGH_RST
  };

  dcf_state_t        st_q;
  dcf_state_t        st_d;

  logic [PIN_W-1:0]  pin_raw;
  logic [PIN_W-1:0]  pin_s;
  logic              rst_n_s;
  logic              wclk_s;
  logic              rclk_s;
  logic              wen_a_n_s;
  logic              wen_b_ld_s;
  logic              ren_a_n_s;
  logic              ren_b_n_s;
  logic              oe_n_s;
  logic [DATA_W-1:0] wdata_s;
  logic [CNT_W-1:0]  wr_gray_s;
  logic [CNT_W-1:0]  rd_gray_s;

  logic              wr_edge;
  logic              rd_edge;
  logic              load_low;
  logic              wr_accept;
  logic              ofs_wr;
  logic              rd_req;
  logic              ofs_rd;
  logic              rd_pop;
  logic              fetch_go;
  logic [CNT_W-1:0]  wr_cnt;
  logic [CNT_W-1:0]  wr_cnt_nx;
  logic [CNT_W-1:0]  rd_side_wr;
  logic [CNT_W-1:0]  rd_cnt_nx;
  logic [CNT_W-1:0]  n_thr;
  logic [CNT_W-1:0]  m_thr;
  logic [OFS_W-1:0]  ofs_cur;
  logic              buf_in_ready;
  logic              buf_out_valid;
  logic [DATA_W-1:0] buf_out_data;

  logic [DATA_W-1:0] mem [0:(1 << ADDR_W) - 1];
  logic [DATA_W-1:0] mem_rd_q;

  // Every pin, the pin clocks included, is sampled as a plain level
  assign pin_raw = {reset_n_in, write_clk_in, read_clk_in, write_enable_a_n_in,
                    write_enable_b_or_load_in, read_enable_a_n_in, read_enable_b_n_in,
                    output_enable_n_in, write_data_in};
  assign {rst_n_s, wclk_s, rclk_s, wen_a_n_s, wen_b_ld_s, ren_a_n_s, ren_b_n_s,
          oe_n_s, wdata_s} = pin_s;

  dcf_sync2 #(.WIDTH(PIN_W)) u_pin_sync (
    .clk_in     (clk_in),
    .sys_rst_in (sys_rst_in),
    .async_in   (pin_raw),
    .sync_out   (pin_s)
  );

  // Write and read sides only exchange registered gray pointers
  dcf_sync2 #(.WIDTH(CNT_W)) u_wr_ptr_sync (
    .clk_in     (clk_in),
    .sys_rst_in (sys_rst_in),
    .async_in   (st_q.wr_gray),
    .sync_out   (wr_gray_s)
  ); // R23

  dcf_sync2 #(.WIDTH(CNT_W)) u_rd_ptr_sync (
    .clk_in     (clk_in),
    .sys_rst_in (sys_rst_in),
    .async_in   (st_q.rd_gray),
    .sync_out   (rd_gray_s)
  ); // R23

  // Array reads take a cycle, so the buffer keeps two words ready
  dcf_buf2 #(.WIDTH(DATA_W)) u_prefetch (
    .clk_in        (clk_in),
    .sys_rst_in    (sys_rst_in),
    .flush_in      (~rst_n_s),
    .in_valid_in   (st_q.fetch_pend),
    .in_data_in    (mem_rd_q),
    .in_ready_out  (buf_in_ready),
    .out_valid_out (buf_out_valid),
    .out_data_out  (buf_out_data),
    .out_ready_in  (rd_pop)
  );

  // Write side
  assign wr_edge   = wclk_s & ~st_q.wclk_prev;
  assign load_low  = (st_q.mode == MODE_PROG_FLAGS) & ~wen_b_ld_s;
  assign wr_accept = wr_edge & rst_n_s & ~wen_a_n_s & wen_b_ld_s & st_q.full_n; // R02 R11 R05 R20
  assign ofs_wr    = wr_edge & rst_n_s & load_low & ~wen_a_n_s; // R13 R24
  assign wr_cnt    = st_q.wr_ptr - dcf_gray2bin(rd_gray_s); // R23
  assign wr_cnt_nx = wr_cnt + CNT_W'(wr_accept);

  // Read side
  assign rd_edge    = rclk_s & ~st_q.rclk_prev;
  assign rd_req     = rd_edge & rst_n_s & ~ren_a_n_s & ~ren_b_n_s;
  assign ofs_rd     = rd_req & load_low; // R15
  assign rd_pop     = rd_req & ~load_low & st_q.empty_n & buf_out_valid; // R04 R06 R21
  assign rd_side_wr = dcf_gray2bin(wr_gray_s); // R23
  assign rd_cnt_nx  = rd_side_wr - st_q.rd_ptr - CNT_W'(rd_pop);
  assign fetch_go   = rst_n_s & buf_in_ready & ~st_q.fetch_pend & (st_q.fetch_ptr != rd_side_wr);

  assign n_thr = {st_q.ofs_eh, st_q.ofs_el}; // R17
  assign m_thr = {st_q.ofs_fh, st_q.ofs_fl}; // R17

  always_comb begin
    case (st_q.ofs_sel)
      OFS_EMPTY_LOW:  ofs_cur = st_q.ofs_el;
      OFS_EMPTY_HIGH: ofs_cur = st_q.ofs_eh;
      OFS_FULL_LOW:   ofs_cur = st_q.ofs_fl;
      OFS_FULL_HIGH:  ofs_cur = st_q.ofs_fh;
      default:        ofs_cur = st_q.ofs_el;
    endcase
  end

  // Array ports sit outside the state record
  always_ff @(posedge clk_in) begin
    if (wr_accept) begin
      mem[st_q.wr_ptr[ADDR_W-1:0]] <= wdata_s; // R03
    end
    if (fetch_go) begin
      mem_rd_q <= mem[st_q.fetch_ptr[ADDR_W-1:0]];
    end
  end

  always_comb begin
    st_d           = st_q;
    st_d.wclk_prev = wclk_s;
    st_d.rclk_prev = rclk_s;
    st_d.oe        = ~oe_n_s; // R09
    if (!rst_n_s) begin
      st_d           = ST_RST; // R07 R22
      st_d.mode      = dcf_mode_t'(wen_b_ld_s); // R10
      st_d.wclk_prev = wclk_s;
      st_d.rclk_prev = rclk_s;
      st_d.oe        = ~oe_n_s;
    end else begin
      if (wr_accept) begin
        st_d.wr_ptr  = st_q.wr_ptr + 16'h0001;
        st_d.wr_gray = dcf_bin2gray(st_q.wr_ptr + 16'h0001); // R23
      end
      if (wr_edge) begin
        st_d.full_n  = wr_cnt_nx != DEPTH; // R20
        st_d.afull_n = (DEPTH - wr_cnt_nx) > m_thr; // R19
      end
      if (ofs_wr) begin
        case (st_q.ofs_sel)
          OFS_EMPTY_LOW:  st_d.ofs_el = wdata_s[OFS_W-1:0]; // R12
          OFS_EMPTY_HIGH: st_d.ofs_eh = wdata_s[OFS_W-1:0];
          OFS_FULL_LOW:   st_d.ofs_fl = wdata_s[OFS_W-1:0];
          OFS_FULL_HIGH:  st_d.ofs_fh = wdata_s[OFS_W-1:0];
          default:        st_d.ofs_el = wdata_s[OFS_W-1:0];
        endcase
      end
      // Position only moves on offset accesses, so it survives load going high
      if (ofs_wr || ofs_rd) begin
        st_d.ofs_sel = dcf_ofs_sel_t'(st_q.ofs_sel + 2'd1); // R13 R14 R15
      end
      st_d.fetch_pend = fetch_go;
      if (fetch_go) begin
        st_d.fetch_ptr = st_q.fetch_ptr + 16'h0001;
      end
      if (rd_pop) begin
        st_d.rd_ptr  = st_q.rd_ptr + 16'h0001;
        st_d.rd_gray = dcf_bin2gray(st_q.rd_ptr + 16'h0001); // R23
        st_d.rdata   = buf_out_data; // R04
      end
      if (ofs_rd) begin
        st_d.rdata = {1'b0, ofs_cur}; // R15
      end
      if (rd_edge) begin
        st_d.empty_n  = rd_cnt_nx != 16'h0000; // R21
        st_d.aempty_n = rd_cnt_nx > n_thr; // R18
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      st_q <= ST_RST;
    end else begin
      st_q <= st_d;
    end
  end

  assign read_data_out      = st_q.rdata;
  assign read_data_oe_out   = st_q.oe;
  assign empty_flag_n_out   = st_q.empty_n;
  assign full_flag_n_out    = st_q.full_n;
  assign almost_empty_n_out = st_q.aempty_n;
  assign almost_full_n_out  = st_q.afull_n;

  default clocking dcf_cb @(posedge clk_in);
  endclocking
  default disable iff (sys_rst_in);

  a_write_stores: assert property ( // R02
    wr_accept |=> (st_q.wr_ptr == $past(st_q.wr_ptr) + 16'h0001)
  ) else $error("accepted write did not advance the write pointer");

  a_full_blocks_write: assert property ( // R05
    wr_edge && rst_n_s && !full_flag_n_out |=> $stable(st_q.wr_ptr)
  ) else $error("write pointer moved while full");

  a_empty_keeps_data: assert property ( // R06
    rd_req && !load_low && !empty_flag_n_out ##1 rst_n_s |-> $stable(read_data_out)
  ) else $error("data output changed on a read while empty");

  a_reset_flags: assert property ( // R07
    !rst_n_s |=> !empty_flag_n_out && !almost_empty_n_out && full_flag_n_out
                 && almost_full_n_out && (read_data_out == READ_DATA_RST)
  ) else $error("flags or data wrong during reset");

  a_oe_follows_pin: assert property ( // R09
    !$past(sys_rst_in, 4) |-> (read_data_oe_out == !$past(output_enable_n_in, 3))
  ) else $error("output drive does not follow the output enable pin");

  a_mode_held: assert property ( // R10
    rst_n_s && $past(rst_n_s) |-> $stable(st_q.mode)
  ) else $error("mode changed outside reset");

  a_ofs_seq_step: assert property ( // R13
    ofs_wr ##1 rst_n_s |-> (st_q.ofs_sel == dcf_ofs_sel_t'($past(st_q.ofs_sel) + 2'd1))
  ) else $error("offset sequence did not step on an offset write");

  a_idle_no_effect: assert property ( // R24
    wr_edge && rst_n_s && load_low && wen_a_n_s && !ofs_rd ##1 rst_n_s
      |-> $stable(st_q.ofs_sel) && $stable(st_q.wr_ptr) && $stable(n_thr) && $stable(m_thr)
  ) else $error("idle load edge changed state");

  a_empty_implies_ae: assert property ( // R18
    !empty_flag_n_out |-> !almost_empty_n_out
  ) else $error("almost empty high while empty");

  a_full_implies_af: assert property ( // R19
    !full_flag_n_out |-> !almost_full_n_out
  ) else $error("almost full high while full");

  // The read pointer copy lags a pin reset by two flops, so the count is only meaningful outside it
  a_count_bound: assert property ( // R01
    rst_n_s |-> wr_cnt <= DEPTH
  ) else $error("unread count above depth");

  a_full_flag_edge: assert property ( // R20
    !wr_edge && rst_n_s ##1 rst_n_s |-> $stable(full_flag_n_out) && $stable(almost_full_n_out)
  ) else $error("write-side flag moved without a write edge");

  a_empty_flag_edge: assert property ( // R21
    !rd_edge && rst_n_s ##1 rst_n_s |-> $stable(empty_flag_n_out) && $stable(almost_empty_n_out)
  ) else $error("read-side flag moved without a read edge");

  c_normal_write: cover property (wr_accept ##[1:200] rd_pop);
  c_reach_full: cover property ($fell(full_flag_n_out));
  c_offset_write: cover property (ofs_wr && (st_q.ofs_sel == OFS_FULL_HIGH));
  c_offset_read: cover property (ofs_rd);

endmodule

// >>> test/dcf_host.sv
// Host-side model of the logic that drives the deep FIFO's pins.
// Assumes clk_in is the device's system clock; pins change on its falling edge.
module dcf_host
  import dcf_pkg::*;
(
  // System clock
  input  wire logic              clk_in,
  // Pins towards the device
  output logic                   reset_n_out,
  output logic                   write_clk_out,
  output logic      [DATA_W-1:0] write_data_out,
  output logic                   write_enable_a_n_out,
  output logic                   write_enable_b_or_load_out,
  output logic                   read_clk_out,
  output logic                   read_enable_a_n_out,
  output logic                   read_enable_b_n_out
);
  initial begin
    reset_n_out                = 1'b1;
    write_clk_out              = 1'b0;
    write_data_out             = 9'h000;
    write_enable_a_n_out       = 1'b1;
    write_enable_b_or_load_out = 1'b1;
    read_clk_out               = 1'b0;
    read_enable_a_n_out        = 1'b1;
    read_enable_b_n_out        = 1'b1;
  end

  task automatic hold(input int c);
    repeat (c) @(negedge clk_in);
  endtask

  // No pin traffic while reset is low; mode level held throughout
  task automatic pin_reset(input logic mode);
    @(negedge clk_in);
    reset_n_out                = 1'b0;
    write_enable_b_or_load_out = mode;
    hold(6);
    reset_n_out = 1'b1;
    hold(5);
  endtask

  // Pin clocks are slow (8 system cycles) so every edge is seen by the device
  task automatic wr(input logic [DATA_W-1:0] d, input logic a_n, input logic b);
    @(negedge clk_in);
    write_data_out             = d;
    write_enable_a_n_out       = a_n;
    write_enable_b_or_load_out = b;
    write_clk_out              = 1'b1;
    hold(4);
    write_clk_out = 1'b0;
    hold(4);
    // Released data line shows the inverse, not a stale copy
    write_data_out       = ~d;
    write_enable_a_n_out = 1'b1;
  endtask

  // Offset reads never overlap offset writes: one strobe at a time
  task automatic rd(input logic a_n, input logic b_n, input logic ld);
    @(negedge clk_in);
    read_enable_a_n_out        = a_n;
    read_enable_b_n_out        = b_n;
    write_enable_b_or_load_out = ld;
    read_clk_out               = 1'b1;
    hold(4);
    read_clk_out = 1'b0;
    hold(4);
    read_enable_a_n_out = 1'b1;
    read_enable_b_n_out = 1'b1;
  endtask
endmodule

// >>> test/tb.sv
// Self-checking bench for the deep FIFO, 16-word build, against a queue model.
// Assumes dcf_host drives the pins; output enable is driven here.
module tb
  import dcf_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  localparam int AW    = 4;
  localparam int DEPTH = 1 << AW;

  logic              clk_in     = 1'b0;
  logic              sys_rst_in = 1'b1;
  logic              oe_n       = 1'b0;
  logic              rst_n;
  logic              wclk;
  logic              rclk;
  logic              wen_a;
  logic              wen_b;
  logic              ren_a;
  logic              ren_b;
  logic [DATA_W-1:0] wdata;
  logic [DATA_W-1:0] rdata;
  logic              oe;
  logic              ef_n;
  logic              ff_n;
  logic              ae_n;
  logic              af_n;
  logic              two_en;
  int                fail_count;
  int                cmp_count;
  int                cyc;
  int                seed;
  int                n_ofs;
  int                m_ofs;
  int                last;
  int                q[$];

  always #12.5 clk_in = ~clk_in;

  dcf_host host (
    .clk_in                     (clk_in),
    .reset_n_out                (rst_n),
    .write_clk_out              (wclk),
    .write_data_out             (wdata),
    .write_enable_a_n_out       (wen_a),
    .write_enable_b_or_load_out (wen_b),
    .read_clk_out               (rclk),
    .read_enable_a_n_out        (ren_a),
    .read_enable_b_n_out        (ren_b)
  );

  dcf_fifo #(.ADDR_W(AW)) uut (
    .clk_in                    (clk_in),
    .sys_rst_in                (sys_rst_in),
    .reset_n_in                (rst_n),
    .write_clk_in              (wclk),
    .write_data_in             (wdata),
    .write_enable_a_n_in       (wen_a),
    .write_enable_b_or_load_in (wen_b),
    .read_clk_in               (rclk),
    .read_enable_a_n_in        (ren_a),
    .read_enable_b_n_in        (ren_b),
    .output_enable_n_in        (oe_n),
    .read_data_out             (rdata),
    .read_data_oe_out          (oe),
    .empty_flag_n_out          (ef_n),
    .full_flag_n_out           (ff_n),
    .almost_empty_n_out        (ae_n),
    .almost_full_n_out         (af_n)
  );

  task automatic end_sim();
    $display("Comparisons %0d, mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fail_count = fail_count + 1;
      end_sim();
    end
  end

  task automatic chk(input string what, input logic [8:0] exp, input logic [8:0] got);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Idle strobes on both pin clocks refresh all four flags
  task automatic flags();
    host.wr(9'h000, 1'b1, 1'b1);
    host.rd(1'b1, 1'b1, 1'b1);
    chk("empty_n", 9'(q.size() != 0), 9'(ef_n));
    chk("almost_empty_n", 9'(q.size() > n_ofs), 9'(ae_n));
    chk("full_n", 9'(q.size() != DEPTH), 9'(ff_n));
    chk("almost_full_n", 9'(DEPTH - q.size() > m_ofs), 9'(af_n));
    chk("oe", 9'(!oe_n), 9'(oe));
  endtask

  task automatic put(input logic a_n, input logic b);
    logic [8:0] d;
    d = 9'($random(seed));
    host.wr(d, a_n, b);
    if (!a_n && b && q.size() < DEPTH) q.push_back(int'(d));
    flags();
  endtask

  task automatic get(input logic a_n, input logic b_n);
    host.rd(a_n, b_n, 1'b1);
    if (!a_n && !b_n && q.size() != 0) last = q.pop_front();
    chk("read_data", 9'(last), rdata);
    flags();
  endtask

  task automatic mix();
    int r;
    r = $random(seed);
    oe_n = r[5];
    if (r[0]) put(r[1] & r[6], two_en ? (r[2] | r[7]) : 1'b1);
    else get(r[1] & r[3], r[2] & r[4]);
  endtask

  task automatic dev_reset(input logic mode);
    host.pin_reset(mode);
    q.delete();
    last   = 0;
    n_ofs  = 7;
    m_ofs  = 7;
    two_en = mode;
    chk("read_data", 9'h000, rdata);
    flags();
  endtask

  task automatic ofs_wr(input logic [7:0] v);
    host.wr({1'b0, v}, 1'b0, 1'b0);
  endtask

  task automatic ofs_rd(input logic [7:0] v);
    host.rd(1'b0, 1'b0, 1'b0);
    last = int'(v);
    chk("offset", {1'b0, v}, rdata);
  endtask

  task automatic run_traffic();
    repeat (DEPTH + 1) put(1'b0, 1'b1);
    repeat (DEPTH + 1) get(1'b0, 1'b0);
    repeat (40) mix();
  endtask

  initial begin
    seed       = 32'h9CBDA019;
    fail_count = 0;
    cmp_count  = 0;
    cyc        = 0;
    repeat (5) @(negedge clk_in);
    sys_rst_in = 1'b0;
    dev_reset(MODE_TWO_ENABLES);
    put(1'b0, 1'b0);
    put(1'b1, 1'b1);
    run_traffic();
    oe_n = 1'b0;
    dev_reset(MODE_PROG_FLAGS);
    ofs_rd(8'h07);
    ofs_rd(8'h00);
    ofs_rd(8'h07);
    ofs_rd(8'h00);
    ofs_wr(8'h03);
    ofs_wr(8'h00);
    host.wr(9'h1FF, 1'b1, 1'b0);
    host.wr(9'h1FF, 1'b1, 1'b1);
    ofs_wr(8'h02);
    ofs_wr(8'h01);
    ofs_wr(8'h05);
    ofs_rd(8'h00);
    ofs_rd(8'h02);
    ofs_rd(8'h01);
    ofs_rd(8'h05);
    n_ofs = 5;
    m_ofs = 258;
    flags();
    run_traffic();
    end_sim();
  end
endmodule
